// *** pfs_pad_mux_top.sv ***
// Shared pad function select and peripheral clock gating
`timescale 1ns/1ns
module pfs_pad_mux_top
  import pfs_pkg::*;
#(
  parameter int NUM_C = 4,
  parameter int NUM_D = 2
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [`PFS_ADDR_W-1:0] reg_addr_in,
  input wire logic [`PFS_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [`PFS_DATA_W-1:0] reg_rdata_out,
  input wire logic [NUM_C-1:0] port_c_peripheral_enable_in,
  input wire logic [NUM_C-1:0] port_c_direction_in,
  input wire logic [NUM_C-1:0] port_c_gpio_data_in,
  output logic [NUM_C-1:0] port_c_pin_level_out,
  input wire logic [NUM_D-1:0] port_d_peripheral_enable_in,
  input wire logic [NUM_D-1:0] port_d_direction_in,
  input wire logic [NUM_D-1:0] port_d_gpio_data_in,
  output logic [NUM_D-1:0] port_d_pin_level_out,
  input wire logic [NUM_C-1:0] timer_output_enable_in,
  input wire logic [NUM_C-1:0] timer_b_channel_data_in,
  output logic [NUM_C-1:0] decoder_timer_pin_out,
  input wire logic [NUM_C-1:0] spi_unit_pin_data_in,
  input wire logic [NUM_C-1:0] spi_unit_pin_oe_in,
  output logic [NUM_C-1:0] spi_unit_pin_out,
  input wire logic [NUM_D-1:0] memory_chip_selects_in,
  input wire logic second_bus_transmit_in,
  output logic second_bus_receive_out,
  input wire logic [NUM_C-1:0] pad_c_in,
  output logic [NUM_C-1:0] pad_c_out,
  output logic [NUM_C-1:0] pad_c_oe_out,
  input wire logic [NUM_D-1:0] pad_d_in,
  output logic [NUM_D-1:0] pad_d_out,
  output logic [NUM_D-1:0] pad_d_oe_out,
  output logic [`PFS_DATA_W-1:0] gated_clk_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  pfs_state_t st_r;
  pfs_state_t st_nxt;
  logic [NUM_C-1:0] sel_c;
  logic [NUM_D-1:0] sel_d;
  logic [`PFS_DATA_W-1:0] status;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  function automatic pfs_pin_mode_t pin_mode(input logic per,
                                             input logic sel);
    pfs_pin_mode_t m;
    m = PFS_MODE_GPIO;
    if (per)
      m = sel ? PFS_MODE_ALT1 : PFS_MODE_ALT0;
    return m;
  endfunction

  function automatic logic [`PFS_DATA_W-1:0] sel_word(
    input logic [`PFS_SEL_W-1:0] sel);
    return {{(`PFS_DATA_W-`PFS_SEL_W){1'b0}}, sel};
  endfunction

  // Separate bit per pin, port C low and port D above
  assign sel_c = st_r.pad_sel[`PFS_SEL_C_LSB +: NUM_C];
  assign sel_d = st_r.pad_sel[`PFS_SEL_D_LSB +: NUM_D];

  // ----------------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    // Read data stands for one cycle only
    st_nxt.rdata = '0;
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        `PFS_OFS_PAD_SEL:
          st_nxt.pad_sel = reg_wdata_in[`PFS_SEL_W-1:0];
        `PFS_OFS_CLK_GATE:
          st_nxt.clk_gate = reg_wdata_in;
        default:
          st_nxt.pad_sel = st_r.pad_sel;
      endcase
    end
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        `PFS_OFS_PAD_SEL:
          st_nxt.rdata = sel_word(st_r.pad_sel);
        `PFS_OFS_CLK_GATE:
          st_nxt.rdata = st_r.clk_gate;
        `PFS_OFS_PAD_STATUS:
          st_nxt.rdata = status;
        default:
          st_nxt.rdata = '0;
      endcase
    end
  end

  // Select resets to ALT0 (decoder/timer on port C, chip selects on port D), clocks all on
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st_r.pad_sel <= `PFS_PAD_SEL_RST;
      st_r.clk_gate <= `PFS_CLK_GATE_RST;
      st_r.rdata <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;

  // ----------------------------------------------------------------------
  // Port C pads
  // ----------------------------------------------------------------------
  // Unrouted peripheral inputs idle high, like a pulled-up pad.
  always_comb
  begin
    pad_c_out = '0;
    pad_c_oe_out = '0;
    decoder_timer_pin_out = '1;
    spi_unit_pin_out = '1;
    for (int i = 0; i < NUM_C; i++)
    begin
      unique case (pin_mode(port_c_peripheral_enable_in[i], sel_c[i]))
        PFS_MODE_GPIO:
        begin
          pad_c_out[i] = port_c_gpio_data_in[i];
          pad_c_oe_out[i] = port_c_direction_in[i];
        end
        PFS_MODE_ALT0:
        begin
          // Decoder side always listens; timer decides drive
          decoder_timer_pin_out[i] = pad_c_in[i];
          pad_c_out[i] = timer_b_channel_data_in[i];
          pad_c_oe_out[i] = timer_output_enable_in[i];
        end
        PFS_MODE_ALT1:
        begin
          spi_unit_pin_out[i] = pad_c_in[i];
          pad_c_out[i] = spi_unit_pin_data_in[i];
          pad_c_oe_out[i] = spi_unit_pin_oe_in[i];
        end
      endcase
    end
  end

  // GPIO always sees the pad level
  assign port_c_pin_level_out = pad_c_in;

  // ----------------------------------------------------------------------
  // Port D pads
  // ----------------------------------------------------------------------
  // Only port D pins 0 and 1 carry the second alternate here.
  always_comb
  begin
    pad_d_out = '0;
    pad_d_oe_out = '0;
    second_bus_receive_out = 1'b1;
    for (int j = 0; j < NUM_D; j++)
    begin
      unique case (pin_mode(port_d_peripheral_enable_in[j], sel_d[j]))
        PFS_MODE_GPIO:
        begin
          pad_d_out[j] = port_d_gpio_data_in[j];
          pad_d_oe_out[j] = port_d_direction_in[j];
        end
        PFS_MODE_ALT0:
        begin
          pad_d_out[j] = memory_chip_selects_in[j];
          pad_d_oe_out[j] = 1'b1;
        end
        PFS_MODE_ALT1:
        begin
          if (j == 0)
          begin
            pad_d_out[j] = second_bus_transmit_in;
            pad_d_oe_out[j] = 1'b1;
          end
          else
          begin
            second_bus_receive_out = pad_d_in[j];
            pad_d_oe_out[j] = 1'b0;
          end
        end
      endcase
    end
  end

  assign port_d_pin_level_out = pad_d_in;

  // ----------------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------------
  always_comb
  begin
    status = '0;
    status[`PFS_SEL_C_LSB +: NUM_C] = port_c_peripheral_enable_in;
    status[`PFS_SEL_D_LSB +: NUM_D] = port_d_peripheral_enable_in;
    status[`PFS_STAT_OE_LSB +: NUM_C] = pad_c_oe_out;
    status[`PFS_STAT_OE_LSB + NUM_C +: NUM_D] = pad_d_oe_out;
  end

  // ----------------------------------------------------------------------
  // Peripheral clock gates
  // ----------------------------------------------------------------------
  // One latch gate per bit; enables come straight from flops.
  for (genvar g = 0; g < `PFS_DATA_W; g++)
  begin : g_gate
    pfs_clk_gate u_gate (
      .clk_in(core_clk_in),
      .enable_in(st_r.clk_gate[g]),
      .gclk_out(gated_clk_out[g])
    );
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  logic [`PFS_DATA_W-1:0] gate_seen;
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      gate_seen <= `PFS_CLK_GATE_RST;
    else if (reg_wr_in && reg_addr_in == `PFS_OFS_CLK_GATE)
      gate_seen <= reg_wdata_in;
  end

  sequence s_sel_write;
    reg_wr_in && reg_addr_in == `PFS_OFS_PAD_SEL;
  endsequence

  sequence s_sel_read;
    reg_rd_in && reg_addr_in == `PFS_OFS_PAD_SEL;
  endsequence

  a_sel_readback: assert property (
    s_sel_write ##1 s_sel_read |=>
      reg_rdata_out == sel_word($past(reg_wdata_in[`PFS_SEL_W-1:0], 2)))
    else $error("pad select readback mismatch");

  a_sel_reserved_zero: assert property (
    s_sel_read |=> reg_rdata_out[`PFS_DATA_W-1:`PFS_SEL_W] == '0)
    else $error("reserved select bits not zero");

  a_sel_next_cycle: assert property (
    s_sel_write |=> st_r.pad_sel == $past(reg_wdata_in[`PFS_SEL_W-1:0]))
    else $error("pad select not updated next cycle");

  a_gate_tracks_write: assert property (
    st_r.clk_gate == gate_seen)
    else $error("clock gate register lost a write");

  a_gate_read_value: assert property (
    reg_rd_in && reg_addr_in == `PFS_OFS_CLK_GATE |=>
      reg_rdata_out == gate_seen)
    else $error("clock gate read mismatch");

  a_read_one_cycle: assert property (
    !reg_rd_in |=> reg_rdata_out == '0)
    else $error("read data stood past its cycle");

  a_gpio_c_dir: assert property (
    ((pad_c_oe_out ^ port_c_direction_in) &
     ~port_c_peripheral_enable_in) == '0)
    else $error("port C GPIO direction wrong");

  a_timer_c_dir: assert property (
    ((pad_c_oe_out ^ timer_output_enable_in) &
     port_c_peripheral_enable_in & ~sel_c) == '0)
    else $error("port C timer direction wrong");

  a_spi_c_route: assert property (
    ((pad_c_out ^ spi_unit_pin_data_in) &
     port_c_peripheral_enable_in & sel_c) == '0)
    else $error("port C SPI data not routed");

  a_cs_d_drive: assert property (
    ((~pad_d_oe_out | (pad_d_out ^ memory_chip_selects_in)) &
     port_d_peripheral_enable_in & ~sel_d) == '0)
    else $error("chip select not driven out");

  a_can_d_dir: assert property (
    port_d_peripheral_enable_in[1] && sel_d[1] |->
      !pad_d_oe_out[1] && second_bus_receive_out == pad_d_in[1])
    else $error("CAN receive pin driven or not routed");

  a_rx_idle_high: assert property (
    !(port_d_peripheral_enable_in[1] && sel_d[1]) |->
      second_bus_receive_out)
    else $error("CAN receive input not idle high");

  a_can_tx_drive: assert property (
    port_d_peripheral_enable_in[0] && sel_d[0] |->
      pad_d_oe_out[0] && pad_d_out[0] == second_bus_transmit_in)
    else $error("CAN transmit pin not driven");

  a_gpio_c_data: assert property (
    ((pad_c_out ^ port_c_gpio_data_in) &
     ~port_c_peripheral_enable_in) == '0)
    else $error("port C GPIO data not driven");

  a_dec_c_listen: assert property (
    ((decoder_timer_pin_out ^ pad_c_in) &
     port_c_peripheral_enable_in & ~sel_c) == '0)
    else $error("decoder does not see pad level");

  a_spi_c_dir: assert property (
    ((pad_c_oe_out ^ spi_unit_pin_oe_in) &
     port_c_peripheral_enable_in & sel_c) == '0)
    else $error("port C SPI direction wrong");

  a_gpio_d_dir: assert property (
    ((pad_d_oe_out ^ port_d_direction_in) &
     ~port_d_peripheral_enable_in) == '0)
    else $error("port D GPIO direction wrong");

  a_unrouted_idle: assert property (
    ((~spi_unit_pin_out) &
     ~(port_c_peripheral_enable_in & sel_c)) == '0)
    else $error("unrouted SPI input not idle high");

  a_gate_next_cycle: assert property (
    reg_wr_in && reg_addr_in == `PFS_OFS_CLK_GATE |=>
      st_r.clk_gate == $past(reg_wdata_in))
    else $error("clock gate not updated next cycle");

endmodule

// *** pfs_params.svh ***
// Register offsets, field positions and reset values of the pad select block
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PFS_ADDR_W 4
`define PFS_DATA_W 16
`define PFS_OFS_PAD_SEL 4'hb
`define PFS_OFS_CLK_GATE 4'hc
`define PFS_OFS_PAD_STATUS 4'hf

// ----------------------------------------------------------------------
// Pad select fields
// ----------------------------------------------------------------------
`define PFS_SEL_W 6
`define PFS_SEL_C_LSB 0
`define PFS_SEL_D_LSB 4
`define PFS_PAD_SEL_RST 6'h00
`define PFS_STAT_OE_LSB 6

// ----------------------------------------------------------------------
// Clock gate fields
// ----------------------------------------------------------------------
`define PFS_CG_EXT_MEM 15
`define PFS_CG_CONV_B 14
`define PFS_CG_CONV_A 13
`define PFS_CG_CAN 12
`define PFS_CG_DECODER_ONE 11
`define PFS_CG_DECODER_ZERO 10
`define PFS_CG_TIMER_D 9
`define PFS_CG_PULSE_A 0
`define PFS_CLK_GATE_RST 16'hffff

`endif

// *** pfs_pkg.sv ***
// Types shared by the pad select and clock gate block
`include "pfs_params.svh"
package pfs_pkg;

  // --------------------------------------------------------------------
  // Pin modes and block state
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    PFS_MODE_GPIO,
    PFS_MODE_ALT0,
    PFS_MODE_ALT1
  } pfs_pin_mode_t;

  typedef struct packed {
    logic [`PFS_SEL_W-1:0] pad_sel;
    logic [`PFS_DATA_W-1:0] clk_gate;
    logic [`PFS_DATA_W-1:0] rdata;
  } pfs_state_t;

endpackage

// *** pfs_clk_gate.sv ***
// Glitch-free clock gate cell for one peripheral clock
`timescale 1ns/1ns
module pfs_clk_gate (
  input wire logic clk_in,
  input wire logic enable_in,
  output logic gclk_out
);

  logic en_latch;

  // ----------------------------------------------------------------------
  // Latch enable while clock low
  // ----------------------------------------------------------------------
  // Enable may only change in the low phase, so no runt pulses.
  always_latch
  begin
    if (!clk_in)
      en_latch <= enable_in;
  end

  assign gclk_out = clk_in & en_latch;

endmodule

// *** pfs_pad_model.sv ***
// Pad and pin-side model driving the pad inputs of the block
`timescale 1ns/1ns
module pfs_pad_model (
  input wire logic [3:0] pad_c_out_in,
  input wire logic [3:0] pad_c_oe_in,
  input wire logic [3:0] ext_c_in,
  output logic [3:0] pad_c_level_out,
  input wire logic [1:0] pad_d_out_in,
  input wire logic [1:0] pad_d_oe_in,
  input wire logic [1:0] ext_d_in,
  output logic [1:0] pad_d_level_out
);
  // ----
  // Wire resolution
  // ----
  // Driven pads show the block's level, others the outside driver
  assign pad_c_level_out = (pad_c_oe_in & pad_c_out_in) |
    (~pad_c_oe_in & ext_c_in);
  assign pad_d_level_out = (pad_d_oe_in & pad_d_out_in) |
    (~pad_d_oe_in & ext_d_in);
endmodule

// *** pfs_pad_mux_top_tb.sv ***
// Self-checking testbench of the pad select and clock gate block
`timescale 1ns/1ns
`include "pfs_params.svh"
module pfs_pad_mux_top_tb;
  import pfs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata, gclk;
  logic [3:0] per_c = 4'hf, dir_c = 4'h0, gpio_c = 4'h0, ext_c = 4'h0;
  logic [3:0] toe = 4'h0, tdata = 4'h0, spi_d = 4'h0, spi_oe = 4'h0;
  logic [3:0] lvl_c, dt_o, spi_o, pc_in, pc_out, pc_oe;
  logic [1:0] per_d = 2'h0, dir_d = 2'h0, gpio_d = 2'h0, ext_d = 2'h0;
  logic [1:0] cs = 2'h0, lvl_d, pd_in, pd_out, pd_oe;
  logic tx = 1'b0;
  logic rx;
  int err_total = 0;
  int n_checks = 0;

  always #20 clk = ~clk;

  pfs_pad_mux_top pfs_pad_mux_top_inst (.core_clk_in(clk),
    .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .port_c_peripheral_enable_in(per_c), .port_c_direction_in(dir_c),
    .port_c_gpio_data_in(gpio_c), .port_c_pin_level_out(lvl_c),
    .port_d_peripheral_enable_in(per_d), .port_d_direction_in(dir_d),
    .port_d_gpio_data_in(gpio_d), .port_d_pin_level_out(lvl_d),
    .timer_output_enable_in(toe), .timer_b_channel_data_in(tdata),
    .decoder_timer_pin_out(dt_o), .spi_unit_pin_data_in(spi_d),
    .spi_unit_pin_oe_in(spi_oe), .spi_unit_pin_out(spi_o),
    .memory_chip_selects_in(cs), .second_bus_transmit_in(tx),
    .second_bus_receive_out(rx), .pad_c_in(pc_in), .pad_c_out(pc_out),
    .pad_c_oe_out(pc_oe), .pad_d_in(pd_in), .pad_d_out(pd_out),
    .pad_d_oe_out(pd_oe), .gated_clk_out(gclk));

  pfs_pad_model pfs_pad_model_inst (.pad_c_out_in(pc_out),
    .pad_c_oe_in(pc_oe), .ext_c_in(ext_c), .pad_c_level_out(pc_in),
    .pad_d_out_in(pd_out), .pad_d_oe_in(pd_oe), .ext_d_in(ext_d),
    .pad_d_level_out(pd_in));

  // ----
  // Shared tasks
  // ----
  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data is only valid in the single cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
    @(posedge clk);
    #1;
    chk("rdata idle", rdata, 16'h0000);
  endtask

  // Write then read with no gap between the two strobes
  task automatic wr_rd_chk(input logic [3:0] a, input logic [15:0] d,
    input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata back to back", rdata, exp);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    rd_chk(`PFS_OFS_PAD_SEL, 16'h0000);
    rd_chk(`PFS_OFS_CLK_GATE, 16'hffff);
    rd_chk(4'h3, 16'h0000);
    wr_reg(`PFS_OFS_PAD_SEL, 16'hffff);
    rd_chk(`PFS_OFS_PAD_SEL, 16'h003f);
    wr_rd_chk(`PFS_OFS_PAD_SEL, 16'hffea, 16'h002a);
    wr_reg(`PFS_OFS_PAD_SEL, 16'h0000);
  endtask

  task automatic t_port_c();
    @(posedge clk);
    per_c <= 4'h0;
    dir_c <= 4'ha;
    gpio_c <= 4'h6;
    ext_c <= 4'h9;
    #1;
    chk("c gpio oe", 16'(pc_oe), 16'h000a);
    chk("c gpio level", 16'(lvl_c), 16'h0003);
    chk("c unrouted", 16'({dt_o, spi_o}), 16'h00ff);
    @(posedge clk);
    per_c <= 4'hf;
    toe <= 4'h3;
    tdata <= 4'h5;
    spi_oe <= 4'hc;
    ext_c <= 4'ha;
    #1;
    chk("c timer oe", 16'(pc_oe), 16'h0003);
    chk("c decoder in", 16'(dt_o), 16'h0009);
    chk("c spi idle", 16'(spi_o), 16'h000f);
    @(posedge clk);
    toe <= 4'ha;
    tdata <= 4'h8;
    spi_oe <= 4'h5;
    spi_d <= 4'h1;
    wr_reg(`PFS_OFS_PAD_SEL, 16'h0005);
    chk("c mixed oe", 16'(pc_oe), 16'h000f);
    chk("c mixed out", 16'(pc_out), 16'h0009);
    chk("c mixed spi in", 16'(spi_o), 16'h000b);
    chk("c mixed dec in", 16'(dt_o), 16'h000d);
    rd_chk(`PFS_OFS_PAD_STATUS, 16'h03cf);
    wr_reg(`PFS_OFS_PAD_SEL, 16'h000f);
    chk("c spi oe", 16'(pc_oe), 16'h0005);
    wr_reg(`PFS_OFS_PAD_SEL, 16'h0000);
  endtask

  task automatic t_port_d();
    @(posedge clk);
    dir_d <= 2'h1;
    gpio_d <= 2'h3;
    #1;
    chk("d gpio oe", 16'(pd_oe), 16'h0001);
    chk("d gpio level", 16'(lvl_d), 16'h0001);
    @(posedge clk);
    per_d <= 2'h3;
    cs <= 2'h2;
    tx <= 1'b1;
    #1;
    chk("d cs oe", 16'(pd_oe), 16'h0003);
    chk("d cs out", 16'(pd_out), 16'h0002);
    chk("d rx idle", 16'(rx), 16'h0001);
    wr_reg(`PFS_OFS_PAD_SEL, 16'h0030);
    chk("d can oe", 16'(pd_oe), 16'h0001);
    chk("d can tx", 16'(pd_out[0]), 16'h0001);
    chk("d can rx", 16'(rx), 16'h0000);
    wr_reg(`PFS_OFS_PAD_SEL, 16'h0020);
    chk("d mixed oe", 16'(pd_oe), 16'h0001);
    chk("d mixed out", 16'(pd_out[0]), 16'h0000);
    wr_reg(`PFS_OFS_PAD_SEL, 16'h0000);
  endtask

  // Walking zero shows each gate is independent of the others
  task automatic t_clk_gate();
    logic [15:0] m;
    for (int i = 0; i < 16; i++)
    begin
      m = ~(16'h0001 << i);
      wr_reg(`PFS_OFS_CLK_GATE, m);
      @(posedge clk);
      #10;
      chk("gclk high", gclk, m);
      #20;
      chk("gclk low", gclk, 16'h0000);
    end
    wr_reg(`PFS_OFS_CLK_GATE, 16'ha5a5);
    rd_chk(`PFS_OFS_CLK_GATE, 16'ha5a5);
    wr_reg(`PFS_OFS_CLK_GATE, 16'hffff);
  endtask

  // Reset in mid-run must bring back select and gate defaults
  task automatic t_reset();
    wr_reg(`PFS_OFS_PAD_SEL, 16'h003f);
    wr_reg(`PFS_OFS_CLK_GATE, 16'h0000);
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk("reset c oe", 16'(pc_oe), 16'h000a);
    @(posedge clk);
    #10;
    chk("reset gclk", gclk, 16'hffff);
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(`PFS_OFS_PAD_SEL, 16'h0000);
    rd_chk(`PFS_OFS_CLK_GATE, 16'hffff);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_port_c();
    t_port_d();
    t_clk_gate();
    t_reset();
    report_and_stop();
  end

  initial
  begin
    #100000;
    err_total++;
    report_and_stop();
  end
endmodule
